// >>> opc_pkg.sv
// package for the optical port pin configuration block
// assumes a single 250 MHz clock domain and an APB register slave
`default_nettype none
package opc_pkg;
	// ==========================================
	// register map: word index, byte address is four times it
	localparam logic [15:0] TX_CTRL_INDEX = 16'h2456;
	localparam logic [15:0] RX_CTRL_INDEX = 16'h2457;
	localparam logic [15:0] TX_CTRL_ADDR = {TX_CTRL_INDEX[13:0], 2'b00};
	localparam logic [15:0] RX_CTRL_ADDR = {RX_CTRL_INDEX[13:0], 2'b00};
	localparam logic [7:0] TX_CTRL_RESET = 8'h00;
	localparam logic [7:0] RX_CTRL_RESET = 8'h00;
	// ==========================================
	// field positions
	localparam int TX_INVERT_BIT = 0;
	localparam int TX_MODULATE_BIT = 1;
	localparam int TX_SELECT_LSB = 2;
	localparam int BITBANG_BIT = 0;
	localparam int RX_INVERT_BIT = 1;
	localparam int RX_DISABLE_BIT = 2;
	localparam int DUTY_LSB = 4;
	// ==========================================
	// encodings
	typedef enum logic [1:0] {
		TX_GENERAL = 2'b00,
		TX_UART = 2'b01,
		TX_REAL_PULSE = 2'b10,
		TX_REACTIVE_PULSE = 2'b11
	} opc_tx_sel_type;
	// modulation period in clocks; 16 gives exact 1/16 steps
	localparam int MOD_PERIOD = 16;
	localparam logic [3:0] MOD_LOW_50 = 4'h8;
	localparam logic [3:0] MOD_LOW_25 = 4'h4;
	localparam logic [3:0] MOD_LOW_12 = 4'h2;
	localparam logic [3:0] MOD_LOW_6 = 4'h1;
endpackage : opc_pkg
`default_nettype wire

// >>> opc_optical_port.sv
// optical port pin configuration: rx pin routing, tx pin selection, modulation
// assumes APB master on clk; segment map bits come from the lcd block
// How it works
// - With bit-bang set, the receive pin goes to a general input and general pin 5 becomes a third UART input.
// - With map bit 55 clear the shared pin feeds the optical UART (bit-bang and disable 0) or general pin 55 (either set), else segment 55.
// - Receive invert flips only the UART's view of the receive comparator, not the general-input view.
// - With map bit 51 clear the tx select chooses general pin, UART tx, real pulse or reactive pulse; set means segment.
// - With modulate set, the carrier replaces the tx output only where it would be zero, after inversion.
// - Transmit invert is applied before modulation.
`timescale 1ns/1ps
`default_nettype none
module opc_optical_port (
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] segment_map_bits,
	input wire logic ir_receive_in,
	input wire logic general_pin_5_in,
	output logic uart_rx_out,
	output logic uart3_rx_out,
	output logic general_pin_55_in,
	output logic shared_pin_is_segment,
	input wire logic uart_tx_in,
	input wire logic general_pin_51_out,
	input wire logic real_energy_pulse,
	input wire logic reactive_energy_pulse,
	output logic ir_transmit_out,
	output logic tx_pin_is_segment
);
	import opc_pkg::*;

	// ==========================================
	// apb registers
	logic [7:0] txCtrl_q;
	logic [7:0] txCtrl_d;
	logic [7:0] rxCtrl_q;
	logic [7:0] rxCtrl_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic hitTx;
	logic hitRx;
	logic access;
	logic setup;

	always_comb begin
		access = psel && penable;
		setup = psel && !penable;
		hitTx = (paddr == TX_CTRL_ADDR);
		hitRx = (paddr == RX_CTRL_ADDR);
		txCtrl_d = txCtrl_q;
		rxCtrl_d = rxCtrl_q;
		// byte-wide registers sit in lane 0
		if (access && pwrite && pstrb[0]) begin
			if (hitTx) begin
				txCtrl_d = pwdata[7:0];
			end
			if (hitRx) begin
				rxCtrl_d = pwdata[7:0];
			end
		end
		// read data latched in the setup cycle, so the bus sees a flop
		prdata_d = prdata_q;
		if (setup) begin
			prdata_d = 32'h0000_0000;
			if (hitTx) begin
				prdata_d = {24'h00_0000, txCtrl_q};
			end else if (hitRx) begin
				prdata_d = {24'h00_0000, rxCtrl_q};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			txCtrl_q <= TX_CTRL_RESET;
			rxCtrl_q <= RX_CTRL_RESET;
			prdata_q <= 32'h0000_0000;
		end else begin
			txCtrl_q <= txCtrl_d;
			rxCtrl_q <= rxCtrl_d;
			prdata_q <= prdata_d;
		end
	end

	// zero-wait slave; unmapped addresses answer with an error
	always_comb begin
		pready = 1'b1;
		pslverr = access && !(hitTx || hitRx);
		prdata = prdata_q;
	end

	// ==========================================
	// field decode
	logic txInvert;
	logic txModulate;
	logic bitbang;
	logic rxInvert;
	logic rxDisable;
	logic [1:0] dutySel;
	opc_tx_sel_type txSel;

	always_comb begin
		txInvert = txCtrl_q[TX_INVERT_BIT];
		txModulate = txCtrl_q[TX_MODULATE_BIT];
		txSel = opc_tx_sel_type'(txCtrl_q[TX_SELECT_LSB +: 2]);
		bitbang = rxCtrl_q[BITBANG_BIT];
		rxInvert = rxCtrl_q[RX_INVERT_BIT];
		rxDisable = rxCtrl_q[RX_DISABLE_BIT];
		dutySel = rxCtrl_q[DUTY_LSB +: 2];
	end

	// ==========================================
	// receive path, registered outputs
	logic uartRx_d;
	logic uartRx_q;
	logic uart3Rx_d;
	logic uart3Rx_q;
	logic gpio55_d;
	logic gpio55_q;
	logic segment_driver_55_d;
	logic segment_driver_55_q;

	always_comb begin
		segment_driver_55_d = segment_map_bits[1];
		// unrouted uart inputs idle high, like a quiet line
		uartRx_d = 1'b1;
		gpio55_d = 1'b0;
		uart3Rx_d = 1'b1;
		if (!segment_map_bits[1]) begin
			if (bitbang || rxDisable) begin
				gpio55_d = ir_receive_in;
			end else begin
				uartRx_d = ir_receive_in ^ rxInvert;
			end
		end
		if (bitbang) begin
			uart3Rx_d = general_pin_5_in;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			uartRx_q <= 1'b1;
			uart3Rx_q <= 1'b1;
			gpio55_q <= 1'b0;
			segment_driver_55_q <= 1'b0;
		end else begin
			uartRx_q <= uartRx_d;
			uart3Rx_q <= uart3Rx_d;
			gpio55_q <= gpio55_d;
			segment_driver_55_q <= segment_driver_55_d;
		end
	end

	always_comb begin
		uart_rx_out = uartRx_q;
		uart3_rx_out = uart3Rx_q;
		general_pin_55_in = gpio55_q;
		shared_pin_is_segment = segment_driver_55_q;
	end

	// ==========================================
	// transmit path
	logic [3:0] modCount_q;
	logic [3:0] modCount_d;
	logic [3:0] lowLen;
	logic txRaw;
	logic txInv;
	logic carrier;
	logic txOut_d;
	logic txOut_q;
	logic txSeg_d;
	logic txSeg_q;

	always_comb begin
		// free running: carrier phase is not tied to tx edges
		modCount_d = modCount_q + 4'h1;
		unique case (dutySel)
			2'b00: lowLen = MOD_LOW_50;
			2'b01: lowLen = MOD_LOW_25;
			2'b10: lowLen = MOD_LOW_12;
			2'b11: lowLen = MOD_LOW_6;
		endcase
		carrier = (modCount_q >= lowLen);
		unique case (txSel)
			TX_GENERAL: txRaw = general_pin_51_out;
			TX_UART: txRaw = uart_tx_in;
			TX_REAL_PULSE: txRaw = real_energy_pulse;
			TX_REACTIVE_PULSE: txRaw = reactive_energy_pulse;
		endcase
		txInv = txRaw ^ txInvert;
		// carrier only fills the zero intervals
		txOut_d = (txModulate && !txInv) ? carrier : txInv;
		txSeg_d = segment_map_bits[0];
		// segment use wins over every source
		if (segment_map_bits[0]) begin
			txOut_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			modCount_q <= 4'h0;
			txOut_q <= 1'b0;
			txSeg_q <= 1'b0;
		end else begin
			modCount_q <= modCount_d;
			txOut_q <= txOut_d;
			txSeg_q <= txSeg_d;
		end
	end

	always_comb begin
		ir_transmit_out = txOut_q;
		tx_pin_is_segment = txSeg_q;
	end
endmodule : opc_optical_port
`default_nettype wire

// >>> opc_ir_model.sv
// ir transceiver model
// bench supplies the light level
`timescale 1ns/1ps
`default_nettype none
module opc_ir_model (
	input wire logic clk,
	input wire logic light,
	output logic rxOut = 1'h0
);
	always @(posedge clk) rxOut <= light;
endmodule : opc_ir_model
`default_nettype wire

// >>> opc_optical_port_asserts.sv
// pin routing invariants
// bound into opc_optical_port
`timescale 1ns/1ps
`default_nettype none
module opc_optical_port_asserts (
	input wire logic clk,
	input wire logic reset,
	input wire logic [1:0] segment_map_bits,
	input wire logic ir_receive_in,
	input wire logic uart_rx_out,
	input wire logic uart3_rx_out,
	input wire logic general_pin_55_in,
	input wire logic ir_transmit_out,
	input wire logic shared_pin_is_segment,
	input wire logic tx_pin_is_segment
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_bitbang_idle: assert property (!uart3_rx_out |-> uart_rx_out) else $error("uart3 and uart both");
	a_rx_exclusive: assert property (!uart_rx_out |-> !general_pin_55_in) else $error("rx routed twice");
	a_gp55_raw: assert property (general_pin_55_in |-> $past(ir_receive_in)) else $error("gp55 inverted");
	a_segment_driver_55_idle: assert property (segment_map_bits[1] |=> uart_rx_out && !general_pin_55_in) else $error("segment_driver_55");
	a_seg51_dark: assert property (segment_map_bits[0] |=> !ir_transmit_out) else $error("seg51");
	a_segment_driver_55_flag: assert property (shared_pin_is_segment == $past(segment_map_bits[1])) else $error("segment_driver_55 flag");
	a_seg51_flag: assert property (tx_pin_is_segment == $past(segment_map_bits[0])) else $error("seg51 flag");
endmodule : opc_optical_port_asserts
bind opc_optical_port opc_optical_port_asserts chk_u (
	.clk(clk),
	.reset(reset),
	.segment_map_bits(segment_map_bits),
	.ir_receive_in(ir_receive_in),
	.uart_rx_out(uart_rx_out),
	.uart3_rx_out(uart3_rx_out),
	.general_pin_55_in(general_pin_55_in),
	.ir_transmit_out(ir_transmit_out),
	.shared_pin_is_segment(shared_pin_is_segment),
	.tx_pin_is_segment(tx_pin_is_segment)
);
`default_nettype wire

// >>> opc_optical_port_tb_top.sv
// optical port bench
// ir model feeds the rx pin
`timescale 1ns/1ps
`default_nettype none
module opc_optical_port_tb_top;
	import opc_pkg::*;
	logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, clr = 0, light = 0, uart_tx_in = 0;
	logic general_pin_5_in = 0, general_pin_51_out = 0, real_energy_pulse = 0, reactive_energy_pulse = 0;
	logic ir_receive_in, pready, pslverr, ir_transmit_out, uart_rx_out, uart3_rx_out, general_pin_55_in;
	logic shared_pin_is_segment, tx_pin_is_segment;
	logic [1:0] segment_map_bits = 0;
	logic [3:0] pstrb = 4'hf;
	logic [15:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic [7:0] lowN, rxv;
	logic irS, gp5S;
	logic [32:0] q[$];
	int n_fail = 0, cmp_count = 0, seed = 18739;
	opc_optical_port dut_u (
		.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.segment_map_bits, .ir_receive_in, .general_pin_5_in, .uart_rx_out, .uart3_rx_out, .general_pin_55_in,
		.shared_pin_is_segment, .uart_tx_in, .general_pin_51_out, .real_energy_pulse, .reactive_energy_pulse,
		.ir_transmit_out, .tx_pin_is_segment
	);
	opc_ir_model ir_u (.clk, .light, .rxOut(ir_receive_in));
	always #2 clk = ~clk;
	task automatic chk(string nm, logic [32:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic test_done;
		$display("compares %0d fails %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done
	task automatic apb(logic w, logic [15:0] a, logic [7:0] d);
		@(posedge clk);
		{psel, pwrite, paddr, pwdata} <= {1'h1, w, a, 24'h0, d};
		if (!w) q.push_back({a != TX_CTRL_ADDR && a != RX_CTRL_ADDR, 24'h0, d});
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'h1);
		{psel, penable} <= 0;
	endtask : apb
	// led lit while the tx pin is low; each run counts two modulation periods
	task automatic tx_run(logic [1:0] seg, logic [3:0] src, logic [7:0] tv, logic [7:0] rv);
		@(posedge clk);
		{segment_map_bits, reactive_energy_pulse, real_energy_pulse, uart_tx_in, general_pin_51_out} <= {seg, src};
		apb(1, TX_CTRL_ADDR, tv);
		apb(0, TX_CTRL_ADDR, tv);
		apb(1, RX_CTRL_ADDR, rv);
		clr <= 1;
		@(posedge clk);
		clr <= 0;
		repeat (2 * MOD_PERIOD) @(posedge clk);
		#1;
	endtask : tx_run
	always @(posedge clk) if (psel && penable && pready && !pwrite) chk("rd", {pslverr, prdata}, q.pop_front());
	always @(posedge clk) {light, general_pin_5_in} <= 2'($random(seed));
	// what the design sampled at the last edge
	always @(posedge clk) {irS, gp5S} <= {ir_receive_in, general_pin_5_in};
	always @(posedge clk) lowN <= clr ? 8'h00 : lowN + 8'(!ir_transmit_out);
	initial begin
		#40000;
		n_fail++;
		test_done();
	end
	initial begin
		repeat (8) @(posedge clk);
		reset <= 0;
		apb(0, TX_CTRL_ADDR, TX_CTRL_RESET);
		apb(0, RX_CTRL_ADDR, RX_CTRL_RESET);
		apb(0, 16'h2458, 8'h00);
		repeat (40) begin
			rxv = 8'($random(seed));
			apb(1, RX_CTRL_ADDR, rxv);
			segment_map_bits <= 2'($random(seed));
			repeat (6) @(posedge clk);
			#1;
			chk("uart rx", uart_rx_out, (segment_map_bits[1] | rxv[0] | rxv[2]) ? 1'b1 : irS ^ rxv[1]);
			chk("gp55", general_pin_55_in, (!segment_map_bits[1] && (rxv[0] | rxv[2])) ? irS : 1'b0);
			chk("uart3", uart3_rx_out, rxv[0] ? gp5S : 1'b1);
			chk("seg flags", {shared_pin_is_segment, tx_pin_is_segment}, segment_map_bits);
		end
		// only the selected source idles low after inversion, so a wrong source leaves no low time and a wrong order leaves the pin low throughout
		for (int d = 0; d < 32; d++) begin
			tx_run(2'b00, {4{~d[4]}} ^ (4'h1 << d[3:2]), {4'h0, d[3:2], 1'b1, d[4]}, {2'b00, d[1:0], 4'h0});
			chk("low count", lowN, MOD_PERIOD >> d[1:0]);
		end
		// carrier off: a zero source holds the pin low throughout
		tx_run(2'b00, 4'h0, 8'h04, 8'h00);
		chk("unmodulated", lowN, 2 * MOD_PERIOD);
		// segment use overrides a source that idles high
		tx_run(2'b01, 4'hf, 8'h06, 8'h00);
		chk("segment 51", lowN, 2 * MOD_PERIOD);
		test_done();
	end
endmodule : opc_optical_port_tb_top
`default_nettype wire
